/* common/sli_flash_if.sv */
`timescale 1ns/10ps
interface sli_flash_if;
  logic fast_ph;
  logic slow_ph;
  modport gen (output fast_ph, output slow_ph);
  modport use_side (input fast_ph, input slow_ph);
endinterface

/* common/sli_pkg.sv */
package sli_pkg;
  localparam int unsigned SLI_CLK_HZ = 125000000;
  // Flash rates in hertz; each phase is half a period.
  localparam int unsigned SLI_FAST_HZ = 2;
  localparam int unsigned SLI_SLOW_HZ = 1;
  localparam int unsigned SLI_FAST_HALF_CYC = SLI_CLK_HZ / (2 * SLI_FAST_HZ);
  localparam int unsigned SLI_SLOW_HALF_CYC = SLI_CLK_HZ / (2 * SLI_SLOW_HZ);
  // Lamp test at power-up, in milliseconds (under one second).
  localparam int unsigned SLI_LAMP_TEST_MS = 500;
  localparam int unsigned SLI_LAMP_TEST_CYC =
    SLI_CLK_HZ / 1000 * SLI_LAMP_TEST_MS;
  // Boot mode all-lamps phase, in milliseconds (3 to 4 seconds).
  localparam int unsigned SLI_BOOT_TEST_MS = 3500;
  localparam int unsigned SLI_BOOT_TEST_CYC =
    SLI_CLK_HZ / 1000 * SLI_BOOT_TEST_MS;
  // Visible stretch of one yellow blink, in milliseconds.
  localparam int unsigned SLI_YEL_MS = 100;
  localparam int unsigned SLI_YEL_CYC = SLI_CLK_HZ / 1000 * SLI_YEL_MS;
  localparam int unsigned SLI_CNT_W = 32;

  typedef enum logic [1:0] {
    SLI_PAT_OFF = 2'b00,
    SLI_PAT_FAST = 2'b01,
    SLI_PAT_SLOW = 2'b10,
    SLI_PAT_ON = 2'b11
  } sli_pat_type;

  typedef enum logic [2:0] {
    SLI_PH_TEST = 3'b000,
    SLI_PH_BOOT_TEST = 3'b001,
    SLI_PH_BOOT = 3'b010,
    SLI_PH_START = 3'b011,
    SLI_PH_NORMAL = 3'b100,
    SLI_PH_OPER = 3'b101
  } sli_phase_type;
endpackage

/* hdl/sli_flash_gen.sv */
`timescale 1ns/10ps
module sli_flash_gen
  import sli_pkg::*;
#(
  parameter int unsigned FAST_HALF = SLI_FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = SLI_SLOW_HALF_CYC
) (
  input wire logic core_clk_in, // System clock.
  input wire logic rst_b_in, // Asynchronous reset, active low.
  sli_flash_if.gen flash // Flash phase outputs.
);
  logic [SLI_CNT_W-1:0] fast_cnt_r;
  logic [SLI_CNT_W-1:0] slow_cnt_r;

  // Both phases come from one clock so the two rates stay aligned.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fast_cnt_r <= '0;
      flash.fast_ph <= 1'b0;
    end else if (fast_cnt_r == SLI_CNT_W'(FAST_HALF - 1)) begin
      fast_cnt_r <= '0;
      flash.fast_ph <= ~flash.fast_ph;
    end else begin
      fast_cnt_r <= fast_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slow_cnt_r <= '0;
      flash.slow_ph <= 1'b0;
    end else if (slow_cnt_r == SLI_CNT_W'(SLOW_HALF - 1)) begin
      slow_cnt_r <= '0;
      flash.slow_ph <= ~flash.slow_ph;
    end else begin
      slow_cnt_r <= slow_cnt_r + 1'b1;
    end
  end
endmodule

/* hdl/sli_status_led.sv */
// Overview of operation
// - Fast flash toggles at 2 Hz, equal on and off halves.
// - Slow flash toggles at 1 Hz, equal on and off halves.
// - After power-up all three lamps light together for under a second.
// - Bootloader: power and alarm steady on, communication lamp dark.
// - Start-up: power lamp fast-flashes, others dark.
// - Normal phase: power lamp steady on, others dark.
// - Operating: fast if measuring off, slow if manual control, else on.
// - Alarm: off, fast on warning, slow on past warning, on for error.
// - Blue: off radio off, fast advertising, slow faulty, on connected.
// - Communication lamp shows only white, blue or yellow.
// - Yellow blink only for valid CRC and supported function code.
// - Yellow blink also needs own slave address.
// - Button held at power-up: lamps lit 3-4 s, then boot lamps.
`timescale 1ns/10ps
module sli_status_led
  import sli_pkg::*;
#(
  parameter int unsigned LAMP_TEST_CYC = SLI_LAMP_TEST_CYC,
  parameter int unsigned BOOT_TEST_CYC = SLI_BOOT_TEST_CYC,
  parameter int unsigned YEL_CYC = SLI_YEL_CYC,
  parameter int unsigned FAST_HALF = SLI_FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = SLI_SLOW_HALF_CYC
) (
  input wire logic core_clk_in, // System clock, 125 MHz.
  input wire logic rst_b_in, // Power-on reset, active low.
  input wire logic button_in, // Push button level, high when pressed.
  input wire logic boot_done_in, // Firmware left bootloader.
  input wire logic startup_done_in, // Start-up phase finished.
  input wire logic operating_in, // Device in operating mode.
  input wire logic is_controller_in, // Variant with control valve.
  input wire logic meas_enabled_in, // Measurement enabled.
  input wire logic ctrl_auto_in, // Control in automatic mode.
  input wire logic warn_active_in, // A warning is active.
  input wire logic warn_past_in, // A warning occurred and cleared.
  input wire logic error_in, // An error is active.
  input wire logic radio_on_in, // Wireless radio powered.
  input wire logic radio_adv_in, // Wireless advertising.
  input wire logic radio_fault_in, // Wireless radio faulty.
  input wire logic radio_conn_in, // Wireless link connected.
  input wire logic mb_req_in, // One-cycle pulse: request received.
  input wire logic mb_crc_ok_in, // Request CRC good.
  input wire logic mb_func_ok_in, // Function code supported.
  input wire logic mb_addr_ok_in, // Address matches own station.
  output logic power_state_lamp_out, // Green lamp drive.
  output logic alarm_lamp_out, // Red lamp drive.
  output logic comm_red_out, // Communication lamp red channel.
  output logic comm_green_out, // Communication lamp green channel.
  output logic comm_blue_out, // Communication lamp blue channel.
  output logic boot_mode_out // High while in bootloader display.
);
  sli_flash_if flash ();
  sli_phase_type phase_r;
  logic [SLI_CNT_W-1:0] ph_cnt_r;
  logic [SLI_CNT_W-1:0] yel_cnt_r;
  logic yel_r;
  logic mb_hit;
  sli_pat_type pwr_pat;
  sli_pat_type alm_pat;
  sli_pat_type blue_pat;
  logic pwr_nxt;
  logic alm_nxt;
  logic blue_nxt;

  sli_flash_gen #(
    .FAST_HALF(FAST_HALF),
    .SLOW_HALF(SLOW_HALF)
  ) u_flash (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .flash(flash)
  );

  function automatic logic pat_lvl(input sli_pat_type p, input logic f,
                                   input logic s);
    logic v;
    v = 1'b0;
    unique case (p)
      SLI_PAT_OFF: v = 1'b0;
      SLI_PAT_FAST: v = f;
      SLI_PAT_SLOW: v = s;
      SLI_PAT_ON: v = 1'b1;
    endcase
    return v;
  endfunction

  // The button is sampled on the last cycle of the lamp test; if it is high
  // then, the longer boot-mode test follows.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_r <= SLI_PH_TEST;
      ph_cnt_r <= '0;
    end else begin
      unique case (phase_r)
        SLI_PH_TEST: begin
          ph_cnt_r <= ph_cnt_r + 1'b1;
          if (ph_cnt_r == SLI_CNT_W'(LAMP_TEST_CYC - 1)) begin
            ph_cnt_r <= '0;
            phase_r <= button_in ? SLI_PH_BOOT_TEST : SLI_PH_START;
          end
        end
        SLI_PH_BOOT_TEST: begin
          ph_cnt_r <= ph_cnt_r + 1'b1;
          if (ph_cnt_r == SLI_CNT_W'(BOOT_TEST_CYC - LAMP_TEST_CYC - 1))
          begin
            ph_cnt_r <= '0;
            phase_r <= SLI_PH_BOOT;
          end
        end
        SLI_PH_BOOT: begin
          if (boot_done_in) begin
            phase_r <= SLI_PH_START;
          end
        end
        SLI_PH_START: begin
          if (startup_done_in) begin
            phase_r <= SLI_PH_NORMAL;
          end
        end
        SLI_PH_NORMAL: begin
          if (operating_in) begin
            phase_r <= SLI_PH_OPER;
          end
        end
        SLI_PH_OPER: begin
          if (!operating_in) begin
            phase_r <= SLI_PH_NORMAL;
          end
        end
        default: begin
          phase_r <= SLI_PH_TEST;
        end
      endcase
    end
  end

  assign mb_hit = mb_req_in & mb_crc_ok_in & mb_func_ok_in
                  & mb_addr_ok_in;

  // A new request restarts the stretch, so a burst reads as one glow.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      yel_cnt_r <= '0;
      yel_r <= 1'b0;
    end else if (mb_hit && phase_r == SLI_PH_OPER) begin
      yel_cnt_r <= SLI_CNT_W'(YEL_CYC - 1);
      yel_r <= 1'b1;
    end else if (yel_cnt_r != '0) begin
      yel_cnt_r <= yel_cnt_r - 1'b1;
    end else begin
      yel_r <= 1'b0;
    end
  end

  always_comb begin
    pwr_pat = SLI_PAT_OFF;
    alm_pat = SLI_PAT_OFF;
    blue_pat = SLI_PAT_OFF;
    unique case (phase_r)
      SLI_PH_TEST, SLI_PH_BOOT_TEST: begin
        pwr_pat = SLI_PAT_ON;
      end
      SLI_PH_BOOT: begin
        pwr_pat = SLI_PAT_ON;
        alm_pat = SLI_PAT_ON;
      end
      SLI_PH_START: pwr_pat = SLI_PAT_FAST;
      SLI_PH_NORMAL: pwr_pat = SLI_PAT_ON;
      SLI_PH_OPER: begin
        if (!meas_enabled_in) begin
          pwr_pat = SLI_PAT_FAST;
        end else if (is_controller_in && !ctrl_auto_in) begin
          pwr_pat = SLI_PAT_SLOW;
        end else begin
          pwr_pat = SLI_PAT_ON;
        end
        if (error_in) begin
          alm_pat = SLI_PAT_ON;
        end else if (warn_active_in) begin
          alm_pat = SLI_PAT_FAST;
        end else if (warn_past_in) begin
          alm_pat = SLI_PAT_SLOW;
        end
        if (!radio_on_in) begin
          blue_pat = SLI_PAT_OFF;
        end else if (radio_fault_in) begin
          blue_pat = SLI_PAT_SLOW;
        end else if (radio_conn_in) begin
          blue_pat = SLI_PAT_ON;
        end else if (radio_adv_in) begin
          blue_pat = SLI_PAT_FAST;
        end
      end
      default: pwr_pat = SLI_PAT_OFF;
    endcase
    pwr_nxt = pat_lvl(pwr_pat, flash.fast_ph, flash.slow_ph);
    alm_nxt = pat_lvl(alm_pat, flash.fast_ph, flash.slow_ph);
    blue_nxt = pat_lvl(blue_pat, flash.fast_ph, flash.slow_ph);
  end

  wire logic all_on = (phase_r == SLI_PH_TEST)
                      || (phase_r == SLI_PH_BOOT_TEST);

  // Lamp test shows white; otherwise blue wins over yellow.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_state_lamp_out <= 1'b0;
      alarm_lamp_out <= 1'b0;
      comm_red_out <= 1'b0;
      comm_green_out <= 1'b0;
      comm_blue_out <= 1'b0;
      boot_mode_out <= 1'b0;
    end else begin
      power_state_lamp_out <= all_on | pwr_nxt;
      alarm_lamp_out <= all_on | alm_nxt;
      boot_mode_out <= (phase_r == SLI_PH_BOOT);
      if (all_on) begin
        comm_red_out <= 1'b1;
        comm_green_out <= 1'b1;
        comm_blue_out <= 1'b1;
      end else if (blue_pat != SLI_PAT_OFF) begin
        comm_red_out <= 1'b0;
        comm_green_out <= 1'b0;
        comm_blue_out <= blue_nxt;
      end else begin
        comm_red_out <= yel_r;
        comm_green_out <= yel_r;
        comm_blue_out <= 1'b0;
      end
    end
  end
endmodule

/* verif/sli_status_led_props.sv */
`timescale 1ns/10ps
module sli_status_led_props
  import sli_pkg::*;
#(
  parameter int unsigned BOOT_TEST_CYC = SLI_BOOT_TEST_CYC
) (
  input wire logic core_clk_in, // Clock.
  input wire logic rst_b_in, // Reset.
  input wire logic boot_done_in, // Phase.
  input wire logic startup_done_in, // Phase.
  input wire logic operating_in, // Phase.
  input wire logic is_controller_in, // Variant.
  input wire logic meas_enabled_in, // Status.
  input wire logic error_in, // Status.
  input wire logic mb_req_in, // Request.
  input wire logic mb_crc_ok_in, // Check.
  input wire logic mb_func_ok_in, // Check.
  input wire logic mb_addr_ok_in, // Check.
  input wire logic power_state_lamp_out, // Lamp.
  input wire logic alarm_lamp_out, // Lamp.
  input wire logic comm_red_out, // Lamp.
  input wire logic comm_green_out, // Lamp.
  input wire logic comm_blue_out, // Lamp.
  input wire logic boot_mode_out // Flag.
);
  // Phase checks wait until any power-up display has surely ended.
  int unsigned up_r;
  logic settled, ops, req_ok;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_r <= 0;
    end else if (!settled) begin
      up_r <= up_r + 1;
    end
  end
  assign settled = up_r > BOOT_TEST_CYC + 2;
  assign ops = settled && boot_done_in && startup_done_in && operating_in;
  assign req_ok = mb_req_in && mb_crc_ok_in && mb_func_ok_in && mb_addr_ok_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_yel_rise;
    $rose(comm_red_out) && !comm_blue_out;
  endsequence
  sequence s_startup;
    (settled && boot_done_in && !startup_done_in) [*8];
  endsequence
  a_lamp_test_all: assert property ($rose(rst_b_in) |-> ##[1:2]
    (power_state_lamp_out && alarm_lamp_out && comm_blue_out))
    else $error("lamp test missing");
  a_comm_colour: assert property (comm_red_out == comm_green_out)
    else $error("comm colour illegal");
  a_boot_lit: assert property (boot_mode_out |->
    power_state_lamp_out && alarm_lamp_out && !comm_red_out &&
    !comm_blue_out) else $error("boot lamps");
  a_white_test: assert property (
    comm_red_out && comm_blue_out |->
    power_state_lamp_out && alarm_lamp_out && !boot_mode_out)
    else $error("white outside lamp test");
  a_yel_cause: assert property (s_yel_rise |->
    $past(req_ok, 2) || $past(req_ok, 3)) else $error("yellow no cause");
  a_yel_stretch: assert property (s_yel_rise |->
    comm_red_out [*5]) else $error("yellow too short");
  a_alarm_error: assert property ((ops && error_in) [*8] |->
    alarm_lamp_out) else $error("error lamp dark");
  a_meas_steady: assert property (
    (ops && meas_enabled_in && !is_controller_in) [*8] |->
    power_state_lamp_out) else $error("power not steady");
  a_fast_half: assert property (
    s_startup ##0 $changed(power_state_lamp_out) |=>
    ($stable(power_state_lamp_out) || startup_done_in ||
    $past(startup_done_in)) [*3]) else $error("fast half short");
  a_startup_dark: assert property (s_startup |-> !alarm_lamp_out &&
    !comm_blue_out && !comm_red_out) else $error("startup lamps lit");
endmodule

bind sli_status_led sli_status_led_props #(.BOOT_TEST_CYC(BOOT_TEST_CYC))
  u_props (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .boot_done_in(boot_done_in), .startup_done_in(startup_done_in),
  .operating_in(operating_in), .is_controller_in(is_controller_in),
  .meas_enabled_in(meas_enabled_in), .error_in(error_in),
  .mb_req_in(mb_req_in), .mb_crc_ok_in(mb_crc_ok_in),
  .mb_func_ok_in(mb_func_ok_in), .mb_addr_ok_in(mb_addr_ok_in),
  .power_state_lamp_out(power_state_lamp_out),
  .alarm_lamp_out(alarm_lamp_out), .comm_red_out(comm_red_out),
  .comm_green_out(comm_green_out), .comm_blue_out(comm_blue_out),
  .boot_mode_out(boot_mode_out));

/* verif/status_led_indicator_controller_tb_top.sv */
`timescale 1ns/10ps
module status_led_indicator_controller_tb_top;
  logic clk = 0, rst_b = 0, btn = 0, bd = 0, sd = 0, op = 0, ctl = 0;
  logic me = 0, au = 0, wa = 0, wp = 0, er = 0, ro = 0, ra = 0, rf = 0;
  logic rc = 0, mr = 0, mc = 0, mf = 0, ma = 0;
  logic [5:0] lamps;
  int bad_count = 0;
  int tests_run = 0;
  // Short counts keep flash periods to a few cycles in simulation.
  sli_status_led #(.LAMP_TEST_CYC(20), .BOOT_TEST_CYC(60), .YEL_CYC(5),
    .FAST_HALF(4), .SLOW_HALF(8)) uut (
    .core_clk_in(clk), .rst_b_in(rst_b), .button_in(btn),
    .boot_done_in(bd), .startup_done_in(sd), .operating_in(op),
    .is_controller_in(ctl), .meas_enabled_in(me), .ctrl_auto_in(au),
    .warn_active_in(wa), .warn_past_in(wp), .error_in(er),
    .radio_on_in(ro), .radio_adv_in(ra), .radio_fault_in(rf),
    .radio_conn_in(rc), .mb_req_in(mr), .mb_crc_ok_in(mc),
    .mb_func_ok_in(mf), .mb_addr_ok_in(ma),
    .power_state_lamp_out(lamps[5]), .alarm_lamp_out(lamps[4]),
    .comm_red_out(lamps[3]), .comm_green_out(lamps[2]),
    .comm_blue_out(lamps[1]), .boot_mode_out(lamps[0]));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic b);
    rst_b <= 0;
    {btn, bd, sd, op, ctl, me, au, wa, wp, er, ro, ra, rf, rc, mr, mc, mf,
      ma} <= {b, 17'h0};
    cyc(3);
    rst_b <= 1;
  endtask
  task automatic half(input int b, output int n);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = lamps[b];
      n = 0;
      while (lamps[b] === v && n < 40) begin
        cyc(1);
        n++;
      end
    end
  endtask
  // Samples four cycles apart catch both flash rates on a steady lamp.
  task automatic pat(input int b, input int code);
    int n;
    cyc(4);
    if (code == 1 || code == 2) begin
      half(b, n);
      chk(8'(n), code == 1 ? 8'h04 : 8'h08);
    end else begin
      for (int k = 0; k < 3; k++) begin
        chk({7'h0, lamps[b]}, {7'h0, code == 3});
        cyc(4);
      end
    end
  endtask
  task automatic pulse(input logic [3:0] q);
    {mr, mc, mf, ma} <= q;
    cyc(1);
    {mr, mc, mf, ma} <= 4'h0;
    cyc(3);
  endtask
  task automatic t_power_up;
    do_reset(0);
    bd <= 1;
    cyc(3);
    chk({2'h0, lamps}, 8'h3e);
    cyc(55);
    pat(5, 1);
    chk({3'h0, lamps[4:0]}, 8'h00);
    sd <= 1;
    pat(5, 3);
    chk({3'h0, lamps[4:0]}, 8'h00);
  endtask
  task automatic t_oper;
    op <= 1;
    me <= 1;
    pat(5, 3);
    me <= 0;
    pat(5, 1);
    {me, ctl} <= 2'h3;
    pat(5, 2);
    au <= 1;
    pat(5, 3);
    {er, wa} <= 2'h3;
    pat(4, 3);
    er <= 0;
    pat(4, 1);
    {wa, wp} <= 2'h1;
    pat(4, 2);
    wp <= 0;
    pat(4, 0);
    {ro, ra} <= 2'h3;
    pat(1, 1);
    rf <= 1;
    pat(1, 2);
    {rf, rc} <= 2'h1;
    pat(1, 3);
    ro <= 0;
    pat(1, 0);
  endtask
  task automatic t_modbus;
    for (int i = 0; i < 5; i++) begin
      pulse(i < 4 ? 4'hf ^ (4'h1 << i) : 4'hf);
      chk({6'h0, lamps[3:2]}, i < 4 ? 8'h00 : 8'h03);
      cyc(8);
      chk({6'h0, lamps[3:2]}, 8'h00);
    end
    {ro, rc} <= 2'h3;
    cyc(4);
    pulse(4'hf);
    chk({5'h0, lamps[3:1]}, 8'h01);
    cyc(10);
  endtask
  task automatic t_boot;
    do_reset(1);
    cyc(40);
    chk({2'h0, lamps[5:1], 1'b0}, 8'h3e);
    cyc(30);
    chk({2'h0, lamps}, 8'h31);
    {btn, bd} <= 2'h1;
    cyc(6);
    chk({7'h0, lamps[0]}, 8'h00);
    pat(5, 1);
    chk({3'h0, lamps[4:0]}, 8'h00);
  endtask
  initial begin
    t_power_up();
    t_oper();
    t_modbus();
    t_boot();
    finish_test();
  end
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule
